// [core/bst_pkg.sv]
// Constants and types shared by the boundary-scan test port
package bst_pkg;
    localparam int          BST_IR_W       = 3;
    localparam int          BST_ID_W       = 32;
    localparam int          BST_BSR_W      = 89;
    localparam logic [2:0]  BST_OP_EXTEST  = 3'h0;
    localparam logic [2:0]  BST_OP_IDCODE  = 3'h1;
    localparam logic [2:0]  BST_OP_SAMPZ   = 3'h2;
    localparam logic [2:0]  BST_OP_SAMPLE  = 3'h4;
    localparam logic [2:0]  BST_OP_BYPASS  = 3'h7;
    localparam logic [1:0]  BST_IR_CAPT    = 2'h1;
    localparam int          BST_RESET_EDGES = 5;
    localparam int          BST_ID_REV_LSB = 29;
    localparam int          BST_ID_DEP_LSB = 24;
    localparam int          BST_ID_WID_LSB = 18;
    localparam int          BST_ID_DEV_LSB = 12;
    localparam int          BST_ID_VEN_LSB = 1;
    localparam int          BST_INT_CELL   = 88;
    localparam logic [BST_BSR_W-1:0] BST_BSR_RST = {1'b1, {(BST_BSR_W-1){1'b0}}};

    typedef enum logic [3:0] {
        BST_TLR, BST_RTI, BST_SEL_DR, BST_CAP_DR, BST_SH_DR, BST_EX1_DR, BST_PA_DR,
        BST_EX2_DR, BST_UP_DR, BST_SEL_IR, BST_CAP_IR, BST_SH_IR, BST_EX1_IR,
        BST_PA_IR, BST_EX2_IR, BST_UP_IR
    } bst_state_e;
endpackage

// [core/bst_sync_if.sv]
// Carrier between the test-clock core and the system-clock sampler
`timescale 1ns/10ps
interface bst_sync_if #(parameter int W = 89);
    logic [W-1:0] ring_q;
    logic         hiz;
    modport core (input ring_q, output hiz);
    modport smp  (output ring_q, input hiz);
endinterface

// [core/bst_sync.sv]
// Two-flop crossing of a level bundle from one clock into another
`timescale 1ns/10ps
module bst_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    typedef struct packed { logic [W-1:0] s1; logic [W-1:0] s2; } bst_sy_s;
    bst_sy_s r;
    bst_sy_s next_r;
    always_comb begin
        next_r    = r;
        next_r.s1 = d_i;
        next_r.s2 = r.s1;
    end
    always_ff @(posedge clk_i) begin
        r <= next_r;
    end
    assign q_o = r.s2;
endmodule

// [core/bst_ring_sampler.sv]
// Samples the I/O ring in the system domain and returns the output-disable level
`timescale 1ns/10ps
module bst_ring_sampler #(
    parameter int W = 89
) (
    input  wire logic         clk_sys_i,
    input  wire logic         srst_i,
    input  wire logic [W-1:0] ring_i,
    output logic              mem_hiz_o,
    bst_sync_if.smp           sif
);
    typedef struct packed { logic [W-1:0] ring; logic hiz; } bst_rs_s;
    bst_rs_s r;
    bst_rs_s next_r;
    logic    hiz_s;
    bst_sync #(.W(1)) u_hiz (.clk_i(clk_sys_i), .d_i(sif.hiz), .q_o(hiz_s));
    always_comb begin
        next_r      = r;
        next_r.ring = ring_i;
        next_r.hiz  = hiz_s;
    end
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end
    assign sif.ring_q = r.ring;
    assign mem_hiz_o  = r.hiz;
endmodule

// [core/bst_test_port.sv]
// Boundary-scan test access port: state machine, instruction and data registers
`timescale 1ns/10ps
module bst_test_port
    import bst_pkg::*;
#(
    parameter logic [2:0] REV_ID = 3'h2,   // Arbitrary identity value
    parameter logic [4:0] DEP_ID = 5'h03,  // Arbitrary identity value
    parameter logic [5:0] WID_ID = 6'h01,  // Arbitrary identity value
    parameter logic [5:0] DEV_ID = 6'h15,  // Arbitrary identity value
    parameter logic [10:0] VEN_ID = 11'h2A5 // Arbitrary identity value
) (
    input  wire logic                       clk_sys_i,
    input  wire logic                       srst_i,
    input  wire logic                       tck_i,
    input  wire logic                       tms_i,
    input  wire logic                       tdi_i,
    output logic                            tdo_o,
    output logic                            tdo_oe_o,
    input  wire logic [bst_pkg::BST_BSR_W-1:0] ring_i,
    output logic [bst_pkg::BST_BSR_W-1:0]   bsr_upd_o,
    output logic                            mem_hiz_o
);
    import bst_pkg::*;
    typedef struct packed {
        bst_state_e           st;
        logic [BST_IR_W-1:0]  ir_sh;
        logic [BST_IR_W-1:0]  ir;
        logic [BST_ID_W-1:0]  id_sh;
        logic [BST_BSR_W-1:0] bsr_sh;
        logic [BST_BSR_W-1:0] bsr_upd;
        logic                 byp;
        logic                 pwr_ok;
    } bst_tp_s;

    bst_tp_s r;
    bst_tp_s next_r;
    logic    tdo_q;
    logic    oe_q;
    logic    ms_q;
    logic    [BST_BSR_W-1:0] ring_t;

    localparam logic [BST_ID_W-1:0] ID_WORD = {REV_ID, DEP_ID, WID_ID, DEV_ID, VEN_ID, 1'b1};

    bst_sync_if #(.W(BST_BSR_W)) sif ();

    bst_ring_sampler #(.W(BST_BSR_W)) u_smp (
        .clk_sys_i (clk_sys_i),
        .srst_i    (srst_i),
        .ring_i    (ring_i),
        .mem_hiz_o (mem_hiz_o),
        .sif       (sif)
    );

    bst_sync #(.W(BST_BSR_W)) u_ring (.clk_i(tck_i), .d_i(sif.ring_q), .q_o(ring_t));

    logic sel_bsr;
    logic sel_id;
    always_comb begin
        sel_bsr = (r.ir == BST_OP_EXTEST) || (r.ir == BST_OP_SAMPZ)
                  || (r.ir == BST_OP_SAMPLE);
        sel_id  = (r.ir == BST_OP_IDCODE);
    end

    always_comb begin
        next_r        = r;
        next_r.pwr_ok = 1'b1;
        case (r.st)
            BST_TLR:    next_r.st = tms_i ? BST_TLR    : BST_RTI;
            BST_RTI:    next_r.st = tms_i ? BST_SEL_DR : BST_RTI;
            BST_SEL_DR: next_r.st = tms_i ? BST_SEL_IR : BST_CAP_DR;
            BST_CAP_DR: next_r.st = tms_i ? BST_EX1_DR : BST_SH_DR;
            BST_SH_DR:  next_r.st = tms_i ? BST_EX1_DR : BST_SH_DR;
            BST_EX1_DR: next_r.st = tms_i ? BST_UP_DR  : BST_PA_DR;
            BST_PA_DR:  next_r.st = tms_i ? BST_EX2_DR : BST_PA_DR;
            BST_EX2_DR: next_r.st = tms_i ? BST_UP_DR  : BST_SH_DR;
            BST_UP_DR:  next_r.st = tms_i ? BST_SEL_DR : BST_RTI;
            BST_SEL_IR: next_r.st = tms_i ? BST_TLR    : BST_CAP_IR;
            BST_CAP_IR: next_r.st = tms_i ? BST_EX1_IR : BST_SH_IR;
            BST_SH_IR:  next_r.st = tms_i ? BST_EX1_IR : BST_SH_IR;
            BST_EX1_IR: next_r.st = tms_i ? BST_UP_IR  : BST_PA_IR;
            BST_PA_IR:  next_r.st = tms_i ? BST_EX2_IR : BST_PA_IR;
            BST_EX2_IR: next_r.st = tms_i ? BST_UP_IR  : BST_SH_IR;
            default:    next_r.st = tms_i ? BST_SEL_DR : BST_RTI;
        endcase
        case (r.st)
            BST_TLR: begin
                next_r.ir      = BST_OP_IDCODE;
                next_r.bsr_upd = BST_BSR_RST;
            end
            BST_CAP_IR: begin
                next_r.ir_sh = {1'b0, BST_IR_CAPT};
            end
            BST_SH_IR: begin
                next_r.ir_sh = {tdi_i, r.ir_sh[BST_IR_W-1:1]};
            end
            BST_UP_IR: begin
                next_r.ir = r.ir_sh;
            end
            BST_CAP_DR: begin
                if (sel_bsr) begin
                    next_r.bsr_sh = {r.bsr_upd[BST_INT_CELL], ring_t[BST_BSR_W-2:0]};
                end else if (sel_id) begin
                    next_r.id_sh = ID_WORD;
                end else begin
                    next_r.byp = 1'b0;
                end
            end
            BST_SH_DR: begin
                if (sel_bsr) begin
                    next_r.bsr_sh = {tdi_i, r.bsr_sh[BST_BSR_W-1:1]};
                end else if (sel_id) begin
                    next_r.id_sh = {tdi_i, r.id_sh[BST_ID_W-1:1]};
                end else begin
                    next_r.byp = tdi_i;
                end
            end
            BST_UP_DR: begin
                if (sel_bsr) begin
                    next_r.bsr_upd = r.bsr_sh;
                end
            end
            default: begin
                next_r.byp = r.byp;
            end
        endcase
        // Power-up flag: anything but a known one forces test-logic-reset
        case (r.pwr_ok)
            1'b1: begin
                next_r.pwr_ok = 1'b1;
            end
            default: begin
                next_r.st      = BST_TLR;
                next_r.ir      = BST_OP_IDCODE;
                next_r.bsr_upd = BST_BSR_RST;
            end
        endcase
    end

    always_ff @(posedge tck_i) begin
        r <= next_r;
    end

    logic tdo_d;
    always_comb begin
        if (r.st == BST_SH_IR) begin
            tdo_d = r.ir_sh[0];
        end else if (sel_bsr) begin
            tdo_d = r.bsr_sh[0];
        end else if (sel_id) begin
            tdo_d = r.id_sh[0];
        end else begin
            tdo_d = r.byp;
        end
    end

    always_ff @(negedge tck_i) begin
        tdo_q <= tdo_d;
        oe_q  <= (r.st == BST_SH_IR) || (r.st == BST_SH_DR);
        ms_q  <= (r.ir == BST_OP_SAMPZ) || ((r.ir == BST_OP_EXTEST)
                 && !r.bsr_upd[BST_INT_CELL]);
    end

    assign sif.hiz   = ms_q;
    assign tdo_o     = tdo_q;
    assign tdo_oe_o  = oe_q;
    assign bsr_upd_o = r.bsr_upd;

    logic [2:0] hi_cnt;
    always_ff @(posedge tck_i) begin
        hi_cnt <= (tms_i && r.pwr_ok) ? ((hi_cnt == 3'h7) ? hi_cnt : hi_cnt + 3'h1) : 3'h0;
    end

    AST_TLR_AFTER_FIVE: assert property (@(posedge tck_i) disable iff (!r.pwr_ok)
        (hi_cnt >= 3'h5) |-> (r.st == BST_TLR)) else $error("five high edges missed reset");
    AST_IR_IDCODE_TLR: assert property (@(posedge tck_i) disable iff (!r.pwr_ok)
        (r.st == BST_TLR) |=> (r.ir == BST_OP_IDCODE)) else $error("reset did not load id op");
    AST_IR_CAPT: assert property (@(posedge tck_i) disable iff (!r.pwr_ok)
        (r.st == BST_CAP_IR) |=> (r.ir_sh[1:0] == BST_IR_CAPT)) else $error("bad ir capture");
    AST_IR_UPD: assert property (@(posedge tck_i) disable iff (!r.pwr_ok)
        (r.st == BST_UP_IR) |=> (r.ir == $past(r.ir_sh))) else $error("ir not applied");
    AST_ID_CAPT: assert property (@(posedge tck_i) disable iff (!r.pwr_ok)
        (r.st == BST_CAP_DR && sel_id) |=> (r.id_sh[0] == 1'b1)) else $error("id bit0 not one");
    AST_BYP_ZERO: assert property (@(posedge tck_i) disable iff (!r.pwr_ok)
        (r.st == BST_CAP_DR && r.ir == BST_OP_BYPASS) |=> !r.byp) else $error("bypass not zero");
    AST_BYP_SHIFT: assert property (@(posedge tck_i) disable iff (!r.pwr_ok)
        (r.st == BST_SH_DR && r.ir == BST_OP_BYPASS) |=> (r.byp == $past(tdi_i))) else $error("bypass shift");
    AST_SEL_IR_TLR: assert property (@(posedge tck_i) disable iff (!r.pwr_ok)
        (r.st == BST_SEL_IR && tms_i) |=> (r.st == BST_TLR)) else $error("bad state step");
    AST_TDO_FALL: assert property (@(negedge tck_i) disable iff (!r.pwr_ok)
        (r.st == BST_SH_DR && sel_id) |=> (tdo_o == $past(r.id_sh[0]))) else $error("tdo wrong");
    COV_IDREAD: cover property (@(posedge tck_i) r.st == BST_SH_DR && sel_id);
    COV_BYPASS: cover property (@(posedge tck_i) r.st == BST_SH_DR && r.ir == BST_OP_BYPASS);
    AST_SEL_DR_STEP: assert property (@(posedge tck_i) disable iff (!r.pwr_ok)
        (r.st == BST_SEL_DR && !tms_i) |=> (r.st == BST_CAP_DR)) else $error("bad dr step");
    AST_SH_IR_STAY: assert property (@(posedge tck_i) disable iff (!r.pwr_ok)
        (r.st == BST_SH_IR && !tms_i) |=> (r.st == BST_SH_IR)) else $error("ir shift left");
    AST_IR_SHIFT: assert property (@(posedge tck_i) disable iff (!r.pwr_ok)
        (r.st == BST_SH_IR) |=> (r.ir_sh[2] == $past(tdi_i))) else $error("ir shift bad");
    AST_IR_HOLD: assert property (@(posedge tck_i) disable iff (!r.pwr_ok)
        (r.st != BST_UP_IR && r.st != BST_TLR) |=> (r.ir == $past(r.ir))) else $error("ir moved");
    AST_ID_WORD: assert property (@(posedge tck_i) disable iff (!r.pwr_ok)
        (r.st == BST_CAP_DR && sel_id) |=> (r.id_sh == ID_WORD)) else $error("id word bad");
    AST_ID_SHIFT: assert property (@(posedge tck_i) disable iff (!r.pwr_ok)
        (r.st == BST_SH_DR && sel_id) |=> (r.id_sh[31] == $past(tdi_i))) else $error("id shift");
    AST_BSR_SHIFT: assert property (@(posedge tck_i) disable iff (!r.pwr_ok)
        (r.st == BST_SH_DR && sel_bsr) |=> (r.bsr_sh[88] == $past(tdi_i))) else $error("bsr shift");
    AST_BSR_INT: assert property (@(posedge tck_i) disable iff (!r.pwr_ok)
        (r.st == BST_CAP_DR && sel_bsr) |=> (r.bsr_sh[88] == $past(r.bsr_upd[88])))
        else $error("internal cell capture");
    AST_UPD_TLR: assert property (@(posedge tck_i) disable iff (!r.pwr_ok)
        (r.st == BST_TLR) |=> (r.bsr_upd == BST_BSR_RST)) else $error("update preset");
    AST_OE_SHIFT: assert property (@(negedge tck_i) disable iff (!r.pwr_ok)
        1'b1 |=> (tdo_oe_o == $past(r.st == BST_SH_IR || r.st == BST_SH_DR)))
        else $error("oe wrong");
    AST_HIZ_SAMPZ: assert property (@(negedge tck_i) disable iff (!r.pwr_ok)
        (r.ir == BST_OP_SAMPZ) |=> ms_q) else $error("sample z not floating");
    AST_HIZ_KEEP: assert property (@(negedge tck_i) disable iff (!r.pwr_ok)
        (r.ir == BST_OP_SAMPLE || r.ir == BST_OP_IDCODE || r.ir == BST_OP_BYPASS) |=> !ms_q)
        else $error("memory disturbed");
    COV_SAMPZ: cover property (@(posedge tck_i) r.st == BST_UP_IR && r.ir_sh == BST_OP_SAMPZ);
    COV_EXT_HIZ: cover property (@(negedge tck_i) r.ir == BST_OP_EXTEST && ms_q);
endmodule

// [dv/bst_ctrl_model.sv]
// Board test controller model driving the scan pins
`timescale 1ns/10ps
module bst_ctrl_model
    import bst_pkg::*;
(
    output logic      tck_o,
    output logic      tms_o,
    output logic      tdi_o,
    input  wire logic tdo_i
);
    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b0;
    end

    // One test-clock period; data out is read just before the rise
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        tms_o = tms;
        tdi_o = tdi;
        #62.5;
        tdo = tdo_i;
        tck_o = 1'b1;
        #62.5;
        tck_o = 1'b0;
    endtask

    // Ends in run-test-idle
    task automatic tap_reset();
        logic d;
        repeat (BST_RESET_EDGES) step(1'b1, 1'b0, d);
        step(1'b0, 1'b0, d);
    endtask

    // Only defined opcodes are handed in by the bench
    task automatic scan(input logic ir, input int w, input logic [88:0] din,
                        output logic [88:0] dout);
        logic d;
        dout = '0;
        step(1'b1, 1'b0, d);
        if (ir) step(1'b1, 1'b0, d);
        step(1'b0, 1'b0, d);
        step(1'b0, 1'b0, d);
        for (int i = 0; i < w; i++) begin
            step(i == w - 1, din[i], d);
            dout[i] = d;
        end
        step(1'b1, 1'b0, d);
        step(1'b0, 1'b0, d);
    endtask
endmodule

// [dv/tb_bst_test_port.sv]
// Self-checking bench of the boundary-scan test port
`timescale 1ns/10ps
module tb_bst_test_port;
    import bst_pkg::*;
    // Arbitrary identity values
    localparam logic [31:0] ID_EXP = {3'h3, 5'h0A, 6'h2C, 6'h11, 11'h155, 1'b1};
    localparam logic [87:0] RING_P = {11{8'hA5}};
    localparam logic [88:0] PRE_Q  = {1'b1, {11{8'h3C}}};
    localparam logic [88:0] EXT_E  = {1'b0, {11{8'hC3}}};
    logic                 clk_sys_i;
    logic                 srst_i;
    logic                 tck_i;
    logic                 tms_i;
    logic                 tdi_i;
    logic                 tdo_o;
    logic                 tdo_oe_o;
    logic                 mem_hiz_o;
    logic [BST_BSR_W-1:0] ring_i;
    logic [BST_BSR_W-1:0] bsr_upd_o;
    logic [88:0]          dout;
    logic                 d;
    int                   errors;
    int                   n_tests;

    bst_test_port #(.REV_ID(3'h3), .DEP_ID(5'h0A), .WID_ID(6'h2C), .DEV_ID(6'h11),
        .VEN_ID(11'h155)) bst_test_port_inst (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
        .tck_i(tck_i), .tms_i(tms_i), .tdi_i(tdi_i), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o),
        .ring_i(ring_i), .bsr_upd_o(bsr_upd_o), .mem_hiz_o(mem_hiz_o));
    bst_ctrl_model bst_ctrl_model_inst (.tck_o(tck_i), .tms_o(tms_i), .tdi_o(tdi_i),
        .tdo_i(tdo_o));

    task automatic test_done();
        if (errors == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input logic [88:0] got, input logic [88:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("wrong value at %0t: %h expected %h", $time, got, exp);
            errors++;
        end
    endtask

    task automatic wait_hiz(input logic exp);
        int k;
        k = 0;
        while (mem_hiz_o !== exp && k < 50) begin
            @(negedge clk_sys_i);
            k++;
        end
        chk(89'(mem_hiz_o), 89'(exp));
    endtask

    task automatic t_id();
        bst_ctrl_model_inst.tap_reset();
        bst_ctrl_model_inst.scan(1'b0, 32, '0, dout);
        chk(dout, 89'(ID_EXP));
        chk(89'(tdo_oe_o), 89'h0);
    endtask

    task automatic t_bypass();
        bst_ctrl_model_inst.scan(1'b1, 3, 89'(BST_OP_BYPASS), dout);
        chk(89'(dout[1:0]), 89'(BST_IR_CAPT));
        bst_ctrl_model_inst.scan(1'b0, 8, 89'h5A, dout);
        chk(dout, 89'hB4);
    endtask

    task automatic t_sample();
        ring_i <= {1'b0, RING_P};
        repeat (20) @(posedge clk_sys_i);
        bst_ctrl_model_inst.scan(1'b1, 3, 89'(BST_OP_SAMPLE), dout);
        bst_ctrl_model_inst.scan(1'b0, 89, PRE_Q, dout);
        chk(dout, {1'b1, RING_P});
        wait_hiz(1'b0);
    endtask

    task automatic t_sampz_extest();
        bst_ctrl_model_inst.scan(1'b1, 3, 89'(BST_OP_SAMPZ), dout);
        wait_hiz(1'b1);
        bst_ctrl_model_inst.scan(1'b1, 3, 89'(BST_OP_IDCODE), dout);
        wait_hiz(1'b0);
        bst_ctrl_model_inst.scan(1'b1, 3, 89'(BST_OP_EXTEST), dout);
        wait_hiz(1'b0);
        bst_ctrl_model_inst.scan(1'b0, 89, EXT_E, dout);
        chk(dout, {PRE_Q[88], RING_P});
        chk(bsr_upd_o, EXT_E);
        wait_hiz(1'b1);
    endtask

    task automatic t_reset_mid();
        bst_ctrl_model_inst.step(1'b1, 1'b0, d);
        bst_ctrl_model_inst.step(1'b0, 1'b0, d);
        bst_ctrl_model_inst.step(1'b0, 1'b0, d);
        repeat (4) bst_ctrl_model_inst.step(1'b0, 1'b1, d);
        bst_ctrl_model_inst.tap_reset();
        wait_hiz(1'b0);
        srst_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        srst_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        wait_hiz(1'b0);
        bst_ctrl_model_inst.scan(1'b0, 32, '0, dout);
        chk(dout, 89'(ID_EXP));
    endtask

    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    initial begin
        #500000;
        errors++;
        test_done();
    end

    initial begin
        errors = 0;
        n_tests = 0;
        srst_i = 1'b1;
        ring_i = '0;
        repeat (3) @(posedge clk_sys_i);
        srst_i <= 1'b0;
        t_id();
        t_bypass();
        t_sample();
        t_sampz_extest();
        t_reset_mid();
        test_done();
    end
endmodule
